// >>> hdl/led_dim_pkg.sv
// Purpose: Shared constants and types for the LED driver control block.
// Assumes: 200 MHz system clock, internal 1 MHz switching oscillator.
// Notes:   All times are kept in their printed unit and turned into counts.
`default_nettype none

package led_dim_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int OSC_PERIOD_NS = 1000;
  localparam int OSC_DIV       = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_NS       = OSC_PERIOD_NS;
  localparam int UP_MIN_US     = 1;
  localparam int UP_MAX_US     = 75;
  localparam int DN_MIN_US     = 180;
  localparam int DN_MAX_US     = 300;
  localparam int OFF_US        = 550;
  localparam int SOFT_US       = 40;
  localparam int PWM_LOW_MS    = 25;
  localparam int SHUTDOWN_MS   = 50;
  localparam logic [9:0] UP_MIN_T = 10'((UP_MIN_US * 1000) / TICK_NS);
  localparam logic [9:0] UP_MAX_T = 10'((UP_MAX_US * 1000) / TICK_NS);
  localparam logic [9:0] DN_MIN_T = 10'((DN_MIN_US * 1000) / TICK_NS);
  localparam logic [9:0] DN_MAX_T = 10'((DN_MAX_US * 1000) / TICK_NS);
  localparam logic [9:0] OFF_T    = 10'((OFF_US * 1000) / TICK_NS);
  localparam logic [5:0] SOFT_T   = 6'((SOFT_US * 1000) / TICK_NS);
  localparam int PWM_LOW_T     = (PWM_LOW_MS * 1000000) / TICK_NS;
  localparam int SHUTDOWN_T    = (SHUTDOWN_MS * 1000000) / TICK_NS;

  // ********************************************************************
  // Setpoint code
  // ********************************************************************
  localparam int         CODE_W    = 5;
  localparam logic [4:0] CODE_MAX  = 5'h1f;
  localparam logic [4:0] CODE_MIN  = 5'h00;
  localparam logic [4:0] CODE_MID  = 5'h10;
  localparam logic [4:0] CODE_FULL = 5'h1f;

  // ********************************************************************
  // Registers
  // ********************************************************************
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] DUTY_OFS   = 8'h04;
  localparam logic [7:0] DUTY_RST   = 8'h60;
  localparam logic [7:0] DUTY_MAX   = 8'hbe;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_PRE  = 2'b01,
    ST_SOFT = 2'b10,
    ST_RUN  = 2'b11
  } pwr_state_t;

  typedef struct packed {
    logic near_vin;
    logic short_gnd;
    logic overvoltage_guard;
    logic undervoltage_lockout;
    logic thermal;
  } fault_t;

  typedef struct packed {
    logic low_switch;
    logic high_switch;
    logic precharge_current;
    logic reduced_limit;
    logic led_on;
  } power_ctrl_t;

endpackage

`default_nettype wire

// >>> hdl/pin_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output var  logic [W-1:0] lvl_o
);

  logic [W-1:0] meta_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        meta_reg[i] <= 1'b0;
        lvl_o[i]    <= 1'b0;
      end else begin
        meta_reg[i] <= pin_i[i];
        lvl_o[i]    <= meta_reg[i];
      end
    end
  end

endmodule // pin_sync

`default_nettype wire

// >>> hdl/pulse_decoder.sv
// Purpose: Classifies low pulses on the brightness programming pin.
// Assumes: Pin level is already synchronised; tick is one cycle per us.
// Notes:   Width is resolved to one oscillator period.
`default_nettype none

module pulse_decoder (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic pin_i,
  output var  logic up_o,
  output var  logic down_o,
  output var  logic off_o
);

  logic       prev_reg, prev_next;
  logic [9:0] cnt_reg, cnt_next;
  logic       up_next, down_next, off_next;
  logic       rise;

  always_comb begin
    rise      = pin_i && !prev_reg;
    prev_next = pin_i;
    cnt_next  = cnt_reg;
    up_next   = 1'b0;
    down_next = 1'b0;
    off_next  = 1'b0;
    if (prev_reg && !pin_i) begin
      cnt_next = 10'h000;
    end else if (!pin_i && tick_i && cnt_reg < led_dim_pkg::OFF_T) begin
      // Counting on the oscillator tick. [RQ19]
      cnt_next = cnt_reg + 10'h001;
      off_next = (cnt_next == led_dim_pkg::OFF_T); // [RQ5]
    end
    if (rise) begin
      // Widths between the windows fall through untouched. [RQ18]
      up_next   = cnt_reg >= led_dim_pkg::UP_MIN_T &&
                  cnt_reg <= led_dim_pkg::UP_MAX_T; // [RQ4]
      down_next = cnt_reg >= led_dim_pkg::DN_MIN_T &&
                  cnt_reg <= led_dim_pkg::DN_MAX_T; // [RQ4]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
      cnt_reg  <= 10'h000;
      up_o     <= 1'b0;
      down_o   <= 1'b0;
      off_o    <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg  <= cnt_next;
      up_o     <= up_next;
      down_o   <= down_next;
      off_o    <= off_next;
    end
  end

  a_gap_ignored : assert property (@(posedge clk_sys_i) // [RQ18]
    disable iff (rst_i)
    (rise && cnt_reg > 10'd75 && cnt_reg < 10'd180) |=> !up_o && !down_o)
    else $error("Pulse between windows changed the code.");

endmodule // pulse_decoder

`default_nettype wire

// >>> hdl/led_dim_ctrl.sv
// Purpose: Digital control of a boost LED driver with pulse dimming.
// Assumes: Analog comparators arrive as asynchronous levels.
// Notes:   APB slave gives status and a duty stand-in for the loop.
// Functional notes
// RQ1: Brightness pin low keeps dimming off and setpoint at full scale.
// RQ2: Brightness pin going high enables dimming at mid code.
// RQ3: Setpoint is a five bit code of 32 levels, 15.6 mV steps.
// RQ4: Low 1 to 75 us raises code; 180 to 300 us lowers it.
// RQ5: Low of 550 us or more switches dimming off.
// RQ6: Host keeps pin high 1.5 us between programming pulses.
// RQ7: Code saturates at both ends until opposite pulse arrives.
// RQ8: Enable high drives LED current, enable low stops it.
// RQ9: Full shutdown only after enable low for 50 ms.
// RQ10: Start in precharge until output is near the input.
// RQ11: After precharge, reduced limit for 40 us, then full regulation.
// RQ12: Output short to ground returns the device to precharge.
// RQ13: Overvoltage stops switching until the comparator clears; code stops the low switch only, high switch keeps toggling.
// RQ14: Undervoltage lockout keeps device off with both switches off.
// RQ15: Thermal alarm turns both switches off until it clears.
// RQ16: Switching runs from a fixed 1 MHz oscillator with set duty.
// RQ17: Enable low of 25 ms or more may already shut down.
// RQ18: Low pulses between the windows leave the code unchanged.
// RQ19: Pulse widths are counted on the internal oscillator.
`default_nettype none

module led_dim_ctrl #(
  parameter int SHUTDOWN_TICKS = led_dim_pkg::SHUTDOWN_T
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_i,
  input  wire logic                     enable_pin_i,
  input  wire logic                     brightness_program_pin_i,
  input  wire led_dim_pkg::fault_t      fault_i,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  output var  led_dim_pkg::power_ctrl_t power_o,
  output var  logic [4:0]               feedback_setpoint_o,
  output var  logic                     dimming_on_o
);

  // ********************************************************************
  // Pin synchronisers and oscillator
  // ********************************************************************
  logic                en_s, pin_s;
  led_dim_pkg::fault_t flt_s;
  logic [7:0]          phase_reg, phase_next;
  logic                tick;

  pin_sync #(.W(7)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     ({enable_pin_i, brightness_program_pin_i, fault_i}),
    .lvl_o     ({en_s, pin_s, flt_s})
  );

  always_comb begin
    tick       = phase_reg == 8'(led_dim_pkg::OSC_DIV - 1); // [RQ16]
    phase_next = tick ? 8'h00 : phase_reg + 8'h01;
  end

  // ********************************************************************
  // Brightness setpoint
  // ********************************************************************
  logic       up_p, down_p, off_p;
  logic       dim_reg, dim_next;
  logic [4:0] code_reg, code_next;

  pulse_decoder u_dec (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .pin_i     (pin_s),
    .up_o      (up_p),
    .down_o    (down_p),
    .off_o     (off_p)
  );

  // The host's 1.5 us high gap is not checked; any shorter high that the synchroniser
  // samples still ends the pulse, and the next low starts a new one. [RQ6]
  always_comb begin
    dim_next  = dim_reg;
    code_next = code_reg;
    if (!dim_reg && pin_s) begin
      dim_next  = 1'b1; // [RQ2]
      code_next = led_dim_pkg::CODE_MID; // [RQ2]
    end else if (dim_reg && off_p) begin
      dim_next = 1'b0; // [RQ5]
    end else if (dim_reg && up_p && code_reg != led_dim_pkg::CODE_MAX) begin
      code_next = code_reg + 5'h01; // [RQ4] [RQ7]
    end else if (dim_reg && down_p &&
                 code_reg != led_dim_pkg::CODE_MIN) begin
      code_next = code_reg - 5'h01; // [RQ4] [RQ7]
    end
  end

  // ********************************************************************
  // Power sequencing
  // ********************************************************************
  led_dim_pkg::pwr_state_t st_reg, st_next;
  logic [15:0] enlow_reg, enlow_next;
  logic [5:0]  soft_reg, soft_next;
  logic [7:0]  duty_reg, duty_next;
  logic [7:0]  duty_eff;
  logic        shutdown;
  led_dim_pkg::power_ctrl_t pwr_next;

  always_comb begin
    // Any limit from 25 ms to 50 ms is legal; the full 50 ms is kept so
    // that slow PWM dimming on enable never drops out. [RQ9] [RQ17]
    enlow_next = enlow_reg;
    if (en_s) begin
      enlow_next = 16'h0000;
    end else if (tick && enlow_reg != 16'hffff) begin
      enlow_next = enlow_reg + 16'h0001;
    end
    shutdown  = !en_s && enlow_reg >= 16'(SHUTDOWN_TICKS); // [RQ9]
    st_next   = st_reg;
    soft_next = soft_reg;
    unique case (st_reg)
      led_dim_pkg::ST_OFF: begin
        if (en_s) begin
          st_next = led_dim_pkg::ST_PRE; // [RQ10]
        end
      end
      led_dim_pkg::ST_PRE: begin
        if (flt_s.near_vin && !flt_s.short_gnd) begin
          st_next   = led_dim_pkg::ST_SOFT; // [RQ10]
          soft_next = 6'h00;
        end
      end
      led_dim_pkg::ST_SOFT: begin
        if (tick) begin
          soft_next = soft_reg + 6'h01;
        end
        if (soft_reg >= led_dim_pkg::SOFT_T) begin
          st_next = led_dim_pkg::ST_RUN; // [RQ11]
        end
      end
      led_dim_pkg::ST_RUN: begin
        st_next = led_dim_pkg::ST_RUN;
      end
    endcase
    if (st_reg != led_dim_pkg::ST_OFF && flt_s.short_gnd) begin
      st_next = led_dim_pkg::ST_PRE; // [RQ12]
    end
    if (flt_s.undervoltage_lockout || shutdown) begin
      st_next = led_dim_pkg::ST_OFF; // [RQ14] [RQ9]
    end
  end

  // The duty register stands in for the current-mode loop; it is clipped
  // to the 95 percent ceiling so the rectifier always gets a window.
  always_comb begin
    duty_eff = (duty_reg > led_dim_pkg::DUTY_MAX) ?
               led_dim_pkg::DUTY_MAX : duty_reg;
    pwr_next.led_on            = en_s && st_reg != led_dim_pkg::ST_OFF;
    pwr_next.reduced_limit     = st_reg == led_dim_pkg::ST_SOFT; // [RQ11]
    pwr_next.precharge_current = st_reg == led_dim_pkg::ST_PRE &&
                                 !flt_s.thermal &&
                                 !flt_s.undervoltage_lockout; // [RQ12]
    pwr_next.low_switch  = (st_reg == led_dim_pkg::ST_SOFT ||
                            st_reg == led_dim_pkg::ST_RUN) &&
                           en_s && !flt_s.overvoltage_guard &&
                           !flt_s.thermal &&
                           !flt_s.undervoltage_lockout &&
                           phase_reg < duty_eff; // [RQ8] [RQ13] [RQ16]
    pwr_next.high_switch = ((st_reg == led_dim_pkg::ST_SOFT ||
                             st_reg == led_dim_pkg::ST_RUN) && en_s &&
                            phase_reg >= duty_eff) ||
                           pwr_next.precharge_current;
    if (flt_s.thermal || flt_s.undervoltage_lockout) begin
      pwr_next.high_switch = 1'b0; // [RQ14] [RQ15]
    end
  end

  // ********************************************************************
  // APB slave
  // ********************************************************************
  logic        setup, access;
  logic [31:0] rdata_next;
  logic        err_next;

  always_comb begin
    setup      = psel && !penable;
    access     = psel && penable && pready;
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    duty_next  = duty_reg;
    unique case (paddr)
      led_dim_pkg::STATUS_OFS: begin
        rdata_next = {18'h0, en_s, flt_s, code_reg, dim_reg, st_reg};
      end
      led_dim_pkg::DUTY_OFS: begin
        rdata_next = {24'h0, duty_reg};
      end
      default: begin
        err_next = 1'b1;
      end
    endcase
    if (access && pwrite && paddr == led_dim_pkg::DUTY_OFS) begin
      duty_next = pwdata[7:0];
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_reg           <= 8'h00;
      dim_reg             <= 1'b0;
      code_reg            <= led_dim_pkg::CODE_MID;
      st_reg              <= led_dim_pkg::ST_OFF;
      enlow_reg           <= 16'h0000;
      soft_reg            <= 6'h00;
      duty_reg            <= led_dim_pkg::DUTY_RST;
      power_o             <= '0;
      feedback_setpoint_o <= led_dim_pkg::CODE_FULL;
      dimming_on_o        <= 1'b0;
      prdata              <= 32'h0000_0000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
    end else begin
      phase_reg           <= phase_next;
      dim_reg             <= dim_next;
      code_reg            <= code_next;
      st_reg              <= st_next;
      enlow_reg           <= enlow_next;
      soft_reg            <= soft_next;
      duty_reg            <= duty_next;
      power_o             <= pwr_next;
      feedback_setpoint_o <= dim_next ? code_next :
                             led_dim_pkg::CODE_FULL; // [RQ1] [RQ3]
      dimming_on_o        <= dim_next;
      prdata              <= setup ? rdata_next : 32'h0000_0000;
      pready              <= setup;
      pslverr             <= setup && err_next;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_full_scale_off : assert property (@(posedge clk_sys_i) // [RQ1]
    disable iff (rst_i)
    !dimming_on_o |-> feedback_setpoint_o == 5'h1f)
    else $error("Setpoint not full scale with dimming off.");
  a_mid_on_enable : assert property (@(posedge clk_sys_i) // [RQ2]
    disable iff (rst_i)
    $rose(dim_reg) |-> code_reg == 5'h10 && feedback_setpoint_o == 5'h10)
    else $error("Dimming did not start at mid code.");
  a_step_up : assert property (@(posedge clk_sys_i) // [RQ4]
    disable iff (rst_i)
    (dim_reg && pin_s && up_p && code_reg != 5'h1f) |=>
      code_reg == $past(code_reg) + 5'h01)
    else $error("Up pulse did not raise the code.");
  a_code_sat : assert property (@(posedge clk_sys_i) // [RQ7]
    disable iff (rst_i)
    (dim_reg && code_reg == 5'h1f && !off_p) |=> code_reg == 5'h1f ||
      $past(down_p))
    else $error("Code left top without a down pulse.");
  a_long_low_off : assert property (@(posedge clk_sys_i) // [RQ5]
    disable iff (rst_i)
    (dim_reg && off_p) |=> !dim_reg ##1 !dimming_on_o)
    else $error("Long low did not end dimming.");
  a_led_gate : assert property (@(posedge clk_sys_i) // [RQ8]
    disable iff (rst_i)
    !en_s |=> !power_o.led_on && !power_o.low_switch)
    else $error("LED current with enable low.");
  a_ovp_stop : assert property (@(posedge clk_sys_i) // [RQ13]
    disable iff (rst_i)
    flt_s.overvoltage_guard |=> !power_o.low_switch)
    else $error("Switching during overvoltage.");
  a_undervoltage_lockout_off : assert property (@(posedge clk_sys_i) // [RQ14]
    disable iff (rst_i)
    flt_s.undervoltage_lockout |=> st_reg == led_dim_pkg::ST_OFF &&
      !power_o.low_switch && !power_o.high_switch)
    else $error("Device not off in undervoltage.");
  a_thermal_off : assert property (@(posedge clk_sys_i) // [RQ15]
    disable iff (rst_i)
    flt_s.thermal |=> !power_o.low_switch && !power_o.high_switch)
    else $error("Switches on during thermal alarm.");
  a_pre_hold : assert property (@(posedge clk_sys_i) // [RQ10]
    disable iff (rst_i)
    (st_reg == led_dim_pkg::ST_PRE && !flt_s.near_vin) |=>
      st_reg != led_dim_pkg::ST_SOFT)
    else $error("Left precharge before output was near input.");
  a_soft_len : assert property (@(posedge clk_sys_i) // [RQ11]
    disable iff (rst_i)
    (st_reg == led_dim_pkg::ST_SOFT && soft_reg < 6'd40) |=>
      st_reg != led_dim_pkg::ST_RUN)
    else $error("Reduced limit ended early.");
  a_short_pre : assert property (@(posedge clk_sys_i) // [RQ12]
    disable iff (rst_i)
    (st_reg == led_dim_pkg::ST_RUN && flt_s.short_gnd &&
     !flt_s.undervoltage_lockout && !shutdown) |=>
      st_reg == led_dim_pkg::ST_PRE)
    else $error("Short did not return to precharge.");
  a_osc_period : assert property (@(posedge clk_sys_i) // [RQ16]
    disable iff (rst_i)
    tick |=> !tick [*8])
    else $error("Oscillator tick too frequent.");
  a_no_early_off : assert property (@(posedge clk_sys_i) // [RQ9]
    disable iff (rst_i)
    (st_reg == led_dim_pkg::ST_RUN && !flt_s.undervoltage_lockout &&
     enlow_reg < 16'(SHUTDOWN_TICKS)) |=> st_reg != led_dim_pkg::ST_OFF)
    else $error("Shutdown before the enable low limit.");

endmodule // led_dim_ctrl

`default_nettype wire

// >>> tb/host_gpio.sv
// Purpose: Host GPIO model driving the enable and brightness pins.
// Assumes: Pins change right after a rising system clock edge.
// Notes:   Timing is counted in 1 us steps of the oscillator divide.
`default_nettype none

module host_gpio (
  input  wire logic clk_i,
  output var  logic enable_pin_o,
  output var  logic brightness_program_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The pull-down on enable means an idle host reads as disabled.
  initial begin
    enable_pin_o = 1'b0;
    brightness_program_pin_o = 1'b0;
  end

  task automatic wait_us(input int us);
    repeat (us * led_dim_pkg::OSC_DIV) @(posedge clk_i);
  endtask

  task automatic set_en(input logic v);
    @(posedge clk_i);
    enable_pin_o <= v;
  endtask

  task automatic set_bright(input logic v);
    @(posedge clk_i);
    brightness_program_pin_o <= v;
  endtask

  // The 2 us gap leaves margin over the minimum high time.
  task automatic pulse(input int us);
    @(posedge clk_i);
    brightness_program_pin_o <= 1'b0;
    wait_us(us);
    brightness_program_pin_o <= 1'b1;
    wait_us(2);
  endtask
endmodule // host_gpio

`default_nettype wire

// >>> tb/test_led_dim_ctrl.sv
// Purpose: Self-checking bench for the LED driver control block.
// Assumes: Shutdown count shortened to 20 us to keep the run short.
// Notes:   Comparator levels are driven directly by the bench.
`default_nettype none

module test_led_dim_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHUT_US = 20;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic                     enable_pin_i;
  logic                     brightness_program_pin_i;
  led_dim_pkg::fault_t      fault_i;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [7:0]               paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  led_dim_pkg::power_ctrl_t power_o;
  logic [4:0]               feedback_setpoint_o;
  logic                     dimming_on_o;
  int                       n_fail = 0;
  int                       n_checks = 0;
  logic [31:0]              seed = 32'h31;
  logic [31:0]              rd;
  logic                     err;

  always #2.5 clk_sys_i = ~clk_sys_i;

  led_dim_ctrl #(.SHUTDOWN_TICKS(SHUT_US)) i_led_dim_ctrl (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .enable_pin_i(enable_pin_i),
    .brightness_program_pin_i(brightness_program_pin_i),
    .fault_i(fault_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_o(power_o),
    .feedback_setpoint_o(feedback_setpoint_o), .dimming_on_o(dimming_on_o)
  );

  host_gpio i_host_gpio (
    .clk_i(clk_sys_i), .enable_pin_o(enable_pin_i),
    .brightness_program_pin_o(brightness_program_pin_i)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv,
                     output logic erv);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) chk(32'h0, 32'h1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic status(input logic [1:0] st);
    apb(1'b0, led_dim_pkg::STATUS_OFS, 32'h0, rd, err);
    chk({30'h0, rd[1:0]}, {30'h0, st});
  endtask

  // Any 200-cycle window holds exactly one full oscillator period.
  task automatic count_ls(input int exp);
    int n;
    n = 0;
    repeat (200) begin
      @(posedge clk_sys_i);
      if (power_o.low_switch === 1'b1) n++;
    end
    chk(32'(n), 32'(exp));
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    // A clean run takes about 100,000 cycles; the limit leaves a margin.
    cyc(120000);
    n_fail++;
    $display("mismatch t=%0t watchdog expired", $time);
    close_out();
  end

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin : main
    logic [7:0] d;
    int         w;
    int         code_m;
    int         q[$];
    fault_i <= '0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    cyc(12);
    rst_i <= 1'b0;
    cyc(4);
    chk({27'h0, feedback_setpoint_o}, 32'h1f);
    chk({31'h0, dimming_on_o}, 32'h0);
    i_host_gpio.set_en(1'b1);
    cyc(20);
    chk({31'h0, power_o.precharge_current}, 32'h1);
    status(led_dim_pkg::ST_PRE);
    fault_i.near_vin <= 1'b1;
    cyc(20 * 200);
    chk({31'h0, power_o.reduced_limit}, 32'h1);
    status(led_dim_pkg::ST_SOFT);
    cyc(25 * 200);
    status(led_dim_pkg::ST_RUN);
    $display("test start-up done");
    d = 8'(xs() % 190) + 8'h01;
    apb(1'b1, led_dim_pkg::DUTY_OFS, {24'h0, d}, rd, err);
    apb(1'b0, led_dim_pkg::DUTY_OFS, 32'h0, rd, err);
    chk(rd, {24'h0, d});
    cyc(200);
    count_ls(int'(d));
    apb(1'b1, led_dim_pkg::DUTY_OFS, 32'hff, rd, err);
    cyc(200);
    count_ls(190);
    apb(1'b0, 8'h08, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    $display("test duty done");
    fault_i.overvoltage_guard <= 1'b1;
    cyc(10);
    count_ls(0);
    fault_i.overvoltage_guard <= 1'b0;
    cyc(10);
    count_ls(190);
    fault_i.thermal <= 1'b1;
    cyc(10);
    chk({30'h0, power_o.low_switch, power_o.high_switch}, 32'h0);
    count_ls(0);
    fault_i.thermal <= 1'b0;
    cyc(10);
    count_ls(190);
    $display("test faults done");
    i_host_gpio.set_en(1'b0);
    cyc(10);
    chk({31'h0, power_o.led_on}, 32'h0);
    i_host_gpio.set_en(1'b1);
    cyc(10);
    chk({31'h0, power_o.led_on}, 32'h1);
    status(led_dim_pkg::ST_RUN);
    fault_i.short_gnd <= 1'b1;
    cyc(10);
    chk({31'h0, power_o.precharge_current}, 32'h1);
    status(led_dim_pkg::ST_PRE);
    fault_i.short_gnd <= 1'b0;
    cyc(45 * 200);
    status(led_dim_pkg::ST_RUN);
    $display("test enable and short done");
    i_host_gpio.set_bright(1'b1);
    cyc(10);
    code_m = 16;
    chk({27'h0, feedback_setpoint_o}, 32'h10);
    chk({31'h0, dimming_on_o}, 32'h1);
    repeat (17) q.push_back(2 + int'(xs() % 4));
    q.push_back(80);
    q.push_back(185);
    while (q.size() > 0) begin
      w = q.pop_front();
      i_host_gpio.pulse(w);
      if (w <= 75) code_m = (code_m < 31) ? code_m + 1 : 31;
      else if (w >= 180 && w <= 300) code_m = (code_m > 0) ? code_m - 1 : 0;
      chk(32'(feedback_setpoint_o), 32'(code_m));
    end
    $display("test brightness done");
    i_host_gpio.set_en(1'b0);
    cyc(10 * 200);
    status(led_dim_pkg::ST_RUN);
    cyc(15 * 200);
    status(led_dim_pkg::ST_OFF);
    chk({27'h0, power_o}, 32'h0);
    fault_i.undervoltage_lockout <= 1'b1;
    i_host_gpio.set_en(1'b1);
    cyc(100);
    status(led_dim_pkg::ST_OFF);
    chk({27'h0, power_o}, 32'h0);
    $display("test shutdown and lockout done");
    close_out();
  end
endmodule // test_led_dim_ctrl

`default_nettype wire
